// *** hw/pca_mode_pkg.sv ***
/*
  Constants for one capture/compare channel of the counter array:
  mode register field positions, reset value and widths.
  Assumes nothing of its surroundings.
*/
package pca_mode_pkg;
  localparam int MODE_WIDTH = 8;
  localparam int COUNT_WIDTH = 16;
  localparam int NARROW_WIDTH = 8;
  localparam int WATCHDOG_CHANNEL = 4;
  localparam logic [MODE_WIDTH-1:0] MODE_RESET = 8'h00;
  localparam int BIT_WIDE_PWM = 7;
  localparam int BIT_COMPARATOR = 6;
  localparam int BIT_RISING_CAPTURE = 5;
  localparam int BIT_FALLING_CAPTURE = 4;
  localparam int BIT_MATCH_FLAG = 3;
  localparam int BIT_TOGGLE = 2;
  localparam int BIT_PWM = 1;
  localparam int BIT_FLAG_IRQ = 0;
  typedef enum logic [1:0] {OUT_IDLE, OUT_TOGGLE, OUT_FREQ, OUT_PWM} out_mode_t;
endpackage

// *** hw/pca_module_mode_control.sv ***
/*
  Mode control of one capture/compare channel: mode register, capture on pin
  edges, match flag, toggle, frequency output and 8/16-bit PWM, interrupt mask
  and the watchdog lock of channel 4.
  Assumes the shared counter, the channel's compare value and the watchdog
  enable come from logic on clock_i; the pin is asynchronous.
*/
// Contract
// - Falling capture enable captures the counter on a falling pin edge.
// - Match flag enable sets the channel flag when counter equals compare value.
// - Toggle enable inverts the pin level on each match.
// - Toggle plus PWM enable selects frequency output mode.
// - PWM enable drives a pulse width modulated waveform on the pin.
// - Wide select clear gives 8-bit PWM, set gives 16-bit PWM.
// - Flag interrupt enable masks the interrupt request of the channel flag.
// - Watchdog enabled: writes to channel 4 mode register are ignored.
// - Rising capture enable captures the counter on a rising pin edge.
// - Both capture enables capture on any pin transition.
// - Comparator enable switches the comparator on; match, toggle, PWM need it.
// - Comparator off: no toggling, PWM outputs constant zero.
`timescale 1ns/1ns
module pca_module_mode_control
#(
  parameter int CHANNEL_INDEX = 0
)
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Mode register access
  input wire logic mode_write_i,
  input wire logic [pca_mode_pkg::MODE_WIDTH-1:0] mode_wdata_i,
  output logic [pca_mode_pkg::MODE_WIDTH-1:0] channel_mode_control_o,
  // Shared counter and compare value
  input wire logic [pca_mode_pkg::COUNT_WIDTH-1:0] counter_i,
  input wire logic [pca_mode_pkg::COUNT_WIDTH-1:0] compare_value_i,
  // Watchdog
  input wire logic watchdog_enable_i,
  // Capture result
  output logic capture_strobe_o,
  output logic [pca_mode_pkg::COUNT_WIDTH-1:0] capture_value_o,
  // Channel flag in the array mode register
  input wire logic flag_clear_i,
  output logic channel_event_flag_o,
  output logic irq_o,
  // Channel pin
  input wire logic channel_pin_i,
  output logic channel_pin_o,
  output logic channel_pin_oe_o
);
  import pca_mode_pkg::*;

  logic [MODE_WIDTH-1:0] mode_q;
  logic rise;
  logic fall;
  logic capture_hit;
  logic full_eq;
  logic narrow_eq;
  logic match_hit;
  logic pwm_high;
  logic wide_below;
  logic write_locked;
  out_mode_t out_mode;
  logic pin_q;
  logic flag_q;
  logic capture_strobe_q;
  logic [COUNT_WIDTH-1:0] capture_value_q;

  pin_edge_detect u_edge
  (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .pin_i(channel_pin_i),
    .rise_o(rise),
    .fall_o(fall)
  );

  // Mode register; channel 4 is frozen while it serves as watchdog
  assign write_locked = (CHANNEL_INDEX == WATCHDOG_CHANNEL) && watchdog_enable_i;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      mode_q <= MODE_RESET;
    else if (mode_write_i && !write_locked)
      mode_q <= mode_wdata_i;
  end

  assign channel_mode_control_o = mode_q;

  // Capture on the enabled edges
  assign capture_hit = (mode_q[BIT_FALLING_CAPTURE] && fall)
    || (mode_q[BIT_RISING_CAPTURE] && rise);

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      capture_strobe_q <= 1'b0;
      capture_value_q <= '0;
    end
    else
    begin
      capture_strobe_q <= capture_hit;
      if (capture_hit)
        capture_value_q <= counter_i;
    end
  end

  assign capture_strobe_o = capture_strobe_q;
  assign capture_value_o = capture_value_q;

  // Comparator; 8-bit PWM and frequency output compare the low byte only
  assign full_eq = counter_i == compare_value_i;
  assign narrow_eq = counter_i[NARROW_WIDTH-1:0] == compare_value_i[NARROW_WIDTH-1:0];

  always_comb
  begin
    if (!mode_q[BIT_TOGGLE] && !mode_q[BIT_PWM])
      out_mode = OUT_IDLE;
    else if (mode_q[BIT_TOGGLE] && mode_q[BIT_PWM])
      out_mode = OUT_FREQ;
    else if (mode_q[BIT_TOGGLE])
      out_mode = OUT_TOGGLE;
    else
      out_mode = OUT_PWM;
  end

  always_comb
  begin
    if (!mode_q[BIT_COMPARATOR])
      match_hit = 1'b0;
    else if ((out_mode == OUT_PWM && !mode_q[BIT_WIDE_PWM]) || out_mode == OUT_FREQ)
      match_hit = narrow_eq;
    else
      match_hit = full_eq;
  end

  // PWM level: high while the counter is below the compare value
  always_comb
  begin
    if (mode_q[BIT_WIDE_PWM])
      pwm_high = counter_i < compare_value_i;
    else
      pwm_high = counter_i[NARROW_WIDTH-1:0] < compare_value_i[NARROW_WIDTH-1:0];
  end

  // Pin driver
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      pin_q <= 1'b0;
    else
    begin
      unique case (out_mode)
        OUT_IDLE: pin_q <= pin_q;
        OUT_TOGGLE, OUT_FREQ:
        begin
          if (match_hit)
            pin_q <= ~pin_q;
        end
        OUT_PWM: pin_q <= mode_q[BIT_COMPARATOR] && pwm_high;
      endcase
    end
  end

  assign channel_pin_o = pin_q;
  assign channel_pin_oe_o = out_mode != OUT_IDLE;

  // Channel flag: a set in the clearing cycle wins; the mask does not gate it
  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      flag_q <= 1'b0;
    else if (capture_hit || (match_hit && mode_q[BIT_MATCH_FLAG]))
      flag_q <= 1'b1;
    else if (flag_clear_i)
      flag_q <= 1'b0;
  end

  assign channel_event_flag_o = flag_q;
  assign irq_o = flag_q && mode_q[BIT_FLAG_IRQ];

  // Assertions
  assign wide_below = counter_i < compare_value_i;
  property p_fall_capture;
    @(posedge clock_i) disable iff (!rst_n_i)
      (mode_q[BIT_FALLING_CAPTURE] && fall)
      |=> capture_strobe_o && capture_value_o == $past(counter_i);
  endproperty
  a_fall_capture: assert property (p_fall_capture)
    else $error("falling edge not captured");

  property p_rise_capture;
    @(posedge clock_i) disable iff (!rst_n_i)
      (mode_q[BIT_RISING_CAPTURE] && rise) |=> capture_strobe_o && channel_event_flag_o;
  endproperty
  a_rise_capture: assert property (p_rise_capture)
    else $error("rising edge not captured");

  property p_no_capture;
    @(posedge clock_i) disable iff (!rst_n_i)
      (!mode_q[BIT_FALLING_CAPTURE] && !mode_q[BIT_RISING_CAPTURE]) |=> !capture_strobe_o;
  endproperty
  a_no_capture: assert property (p_no_capture)
    else $error("capture with both edges off");

  property p_match_flag;
    @(posedge clock_i) disable iff (!rst_n_i)
      (mode_q[BIT_COMPARATOR] && mode_q[BIT_MATCH_FLAG] && !mode_q[BIT_PWM] && full_eq)
      |=> channel_event_flag_o;
  endproperty
  a_match_flag: assert property (p_match_flag)
    else $error("match did not set flag");

  property p_toggle;
    @(posedge clock_i) disable iff (!rst_n_i)
      (out_mode == OUT_TOGGLE && mode_q[BIT_COMPARATOR] && full_eq)
      |=> channel_pin_o != $past(channel_pin_o);
  endproperty
  a_toggle: assert property (p_toggle) else $error("pin did not toggle on match");

  property p_freq;
    @(posedge clock_i) disable iff (!rst_n_i)
      (out_mode == OUT_FREQ && mode_q[BIT_COMPARATOR] && narrow_eq)
      |=> channel_pin_o != $past(channel_pin_o);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency output did not toggle");

  property p_pwm_level;
    @(posedge clock_i) disable iff (!rst_n_i)
      (out_mode == OUT_PWM && mode_q[BIT_COMPARATOR] && mode_q[BIT_WIDE_PWM]) ##1 $stable(mode_q)
      |-> channel_pin_o == $past(wide_below);
  endproperty
  a_pwm_level: assert property (p_pwm_level)
    else $error("16-bit pwm level wrong");

  property p_comp_off;
    @(posedge clock_i) disable iff (!rst_n_i)
      (out_mode == OUT_PWM && !mode_q[BIT_COMPARATOR]) |=> !channel_pin_o;
  endproperty
  a_comp_off: assert property (p_comp_off)
    else $error("pwm not zero with comparator off");

  property p_irq_mask;
    @(posedge clock_i) disable iff (!rst_n_i)
      irq_o == (channel_event_flag_o && mode_q[BIT_FLAG_IRQ]);
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("interrupt mask wrong");

  property p_lock;
    @(posedge clock_i) disable iff (!rst_n_i)
      write_locked |=> $stable(channel_mode_control_o);
  endproperty
  a_lock: assert property (p_lock) else $error("locked mode register changed");

  property p_write;
    @(posedge clock_i) disable iff (!rst_n_i)
      (mode_write_i && !write_locked) |=> channel_mode_control_o == $past(mode_wdata_i);
  endproperty
  a_write: assert property (p_write) else $error("mode write lost");

  property p_set_wins;
    @(posedge clock_i) disable iff (!rst_n_i)
      (flag_clear_i && capture_hit) |=> channel_event_flag_o;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("flag set lost to clear");

  c_capture: cover property (@(posedge clock_i) disable iff (!rst_n_i) capture_strobe_o);
  c_toggle: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    out_mode == OUT_TOGGLE && match_hit);
  c_pwm: cover property (@(posedge clock_i) disable iff (!rst_n_i)
    out_mode == OUT_PWM && $rose(channel_pin_o));
  c_irq: cover property (@(posedge clock_i) disable iff (!rst_n_i) $rose(irq_o));
endmodule

// *** hw/pin_edge_detect.sv ***
/*
  Synchronises the channel pin into the clock domain and flags its edges.
  Assumes the pin is asynchronous to clock_i.
*/
`timescale 1ns/1ns
module pin_edge_detect
(
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Pin
  input wire logic pin_i,
  // Edges
  output logic rise_o,
  output logic fall_o
);
  logic meta_q;
  logic sync_q;
  logic prev_q;

  always_ff @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      meta_q <= pin_i;
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  assign rise_o = sync_q & ~prev_q;
  assign fall_o = ~sync_q & prev_q;
endmodule

// *** verif/pin_source.sv ***
/*
  External source driving the channel pin.
  Assumes the bench asks for a pin level on the clock's rising edge.
*/
`timescale 1ns/1ns
module pin_source
(
  // Clock
  input wire logic clock_i,
  // Requested level
  input wire logic level_i,
  // Pin
  output logic pin_o
);
  // Level moves just after an edge, as a real source would
  always_ff @(posedge clock_i)
  begin
    pin_o <= level_i;
  end
endmodule

// *** verif/tb.sv ***
/*
  Self-checking bench for the channel mode control, run as channel 4.
  Assumes the pin source model and the channel package.
*/
`timescale 1ns/1ns
module tb;
  import pca_mode_pkg::*;
  logic clock_i = 0;
  logic rst_n_i = 0;
  logic wr = 0;
  logic [MODE_WIDTH-1:0] wd = 8'h00;
  logic [COUNT_WIDTH-1:0] cnt = 16'h1234;
  logic [COUNT_WIDTH-1:0] cmp = 16'h0080;
  logic wdog = 0, clr = 0, lvl = 0, p;
  logic [MODE_WIDTH-1:0] mode;
  logic strobe, flag, irq, pin_d, oe, src;
  logic [COUNT_WIDTH-1:0] cap;
  // Resolved pin: the channel wins while it drives
  wire pin_w = oe ? pin_d : src;
  int err_total = 0;
  int total_checks = 0;

  pin_source src_m (.clock_i(clock_i), .level_i(lvl), .pin_o(src));
  pca_module_mode_control #(.CHANNEL_INDEX(WATCHDOG_CHANNEL)) uut (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .mode_write_i(wr), .mode_wdata_i(wd),
    .channel_mode_control_o(mode), .counter_i(cnt), .compare_value_i(cmp),
    .watchdog_enable_i(wdog), .capture_strobe_o(strobe), .capture_value_o(cap),
    .flag_clear_i(clr), .channel_event_flag_o(flag), .irq_o(irq),
    .channel_pin_i(pin_w), .channel_pin_o(pin_d), .channel_pin_oe_o(oe));

  initial
  begin
    forever #5 clock_i = ~clock_i;
  end

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic write_mode(input logic [7:0] d);
    @(posedge clock_i);
    wr <= 1'b1;
    wd <= d;
    @(posedge clock_i);
    wr <= 1'b0;
    #1;
  endtask

  // Moves the pin and watches a bounded span for a capture
  task automatic edge_to(input logic level, input logic exp);
    logic seen;
    seen = 0;
    @(posedge clock_i);
    lvl <= level;
    repeat (8)
    begin
      @(posedge clock_i);
      #1;
      if (strobe === 1'b1)
        seen = 1;
    end
    chk("capture strobe", 16'(exp), 16'(seen));
    if (exp)
      chk("capture value", cnt, cap);
  endtask

  // One cycle with the counter at c, pin level remembered first
  task automatic match(input logic [15:0] c);
    p = pin_d;
    @(posedge clock_i);
    cnt <= c;
    @(posedge clock_i);
    cnt <= 16'h1234;
    #1;
  endtask

  task automatic pulse_clear();
    @(posedge clock_i);
    clr <= 1'b1;
    @(posedge clock_i);
    clr <= 1'b0;
    #1;
  endtask

  initial
  begin
    repeat (10) @(posedge clock_i);
    rst_n_i <= 1'b1;
    #1;
    chk("mode reset", 16'(MODE_RESET), 16'(mode));
    chk("pin enable reset", 16'h0000, 16'(oe));
    write_mode(8'h30);
    chk("mode", 16'h0030, 16'(mode));
    chk("pin enable capture", 16'h0000, 16'(oe));
    edge_to(1'b1, 1'b1);
    chk("flag", 16'h0001, 16'(flag));
    chk("irq masked", 16'h0000, 16'(irq));
    @(posedge clock_i);
    cnt <= 16'h0f0f;
    edge_to(1'b0, 1'b1);
    write_mode(8'h10);
    edge_to(1'b1, 1'b0);
    edge_to(1'b0, 1'b1);
    write_mode(8'h11);
    chk("irq", 16'h0001, 16'(irq));
    pulse_clear();
    chk("irq cleared", 16'h0000, 16'(irq));
    // Falling capture lands in a clearing cycle: the set must win
    @(posedge clock_i);
    lvl <= 1'b1;
    repeat (6) @(posedge clock_i);
    clr <= 1'b1;
    lvl <= 1'b0;
    repeat (4) @(posedge clock_i);
    clr <= 1'b0;
    #1;
    chk("flag set beats clear", 16'h0001, 16'(flag));
    pulse_clear();
    write_mode(8'h48);
    match(16'h0080);
    chk("match flag", 16'h0001, 16'(flag));
    pulse_clear();
    write_mode(8'h08);
    match(16'h0080);
    chk("flag comparator off", 16'h0000, 16'(flag));
    write_mode(8'h44);
    chk("pin enable toggle", 16'h0001, 16'(oe));
    match(16'h0080);
    chk("toggle", 16'(!p), 16'(pin_w));
    write_mode(8'h04);
    match(16'h0080);
    chk("no toggle", 16'(p), 16'(pin_w));
    @(posedge clock_i);
    cmp <= 16'h0005;
    write_mode(8'h46);
    match(16'hab05);
    chk("frequency toggle", 16'(!p), 16'(pin_w));
    write_mode(8'h44);
    match(16'hab05);
    chk("wide compare", 16'(p), 16'(pin_w));
    @(posedge clock_i);
    cmp <= 16'h0080;
    cnt <= 16'hff10;
    write_mode(8'h42);
    repeat (2) @(posedge clock_i);
    #1;
    chk("pwm narrow", 16'h0001, 16'(pin_w));
    write_mode(8'hc2);
    repeat (2) @(posedge clock_i);
    #1;
    chk("pwm wide", 16'h0000, 16'(pin_w));
    @(posedge clock_i);
    cnt <= 16'h0010;
    repeat (2) @(posedge clock_i);
    #1;
    chk("pwm wide low", 16'h0001, 16'(pin_w));
    write_mode(8'h82);
    repeat (2) @(posedge clock_i);
    #1;
    chk("pwm comparator off", 16'h0000, 16'(pin_w));
    chk("pin enable pwm", 16'h0001, 16'(oe));
    @(posedge clock_i);
    wdog <= 1'b1;
    write_mode(8'hff);
    chk("locked mode", 16'h0082, 16'(mode));
    @(posedge clock_i);
    wdog <= 1'b0;
    write_mode(8'h55);
    chk("unlocked mode", 16'h0055, 16'(mode));
    summarize();
  end

  initial
  begin
    #100000;
    err_total++;
    summarize();
  end
endmodule
